// >>> logic/aux_io_exec.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE1 - Group 3 needs bits 3 and 11 set
// RULE2 - Bits 4,5,7 combine; clear before moves
// RULE3 - 7501 ORs aux into work
// RULE4 - 7421 moves work to aux, clears work
// RULE5 - 7701 loads work from aux
// RULE6 - 7621 clears both registers
// RULE7 - 7521 swaps work and aux
// RULE8 - 7721 work gets aux, aux cleared
// RULE9 - Top bits 110 mean io transfer
// RULE10 - Peripheral interprets low nine bits freely
// RULE11 - Peripheral: bits 3-8 device, 9-11 operation
// RULE12 - Five state fetch, then phases A, B
// RULE13 - Phase A puts instruction on bus
// RULE14 - Peripheral latches word at address strobe
// RULE15 - Select driven low for data exchange
// RULE16 - Peripheral drives code and skip lines
// RULE17 - Skip line low skips next instruction
// RULE18 - Skip independent of code lines
// RULE19 - Jump first, then skip increment
// RULE20 - Sample bus and lines at state 3
// RULE21 - Work data out during select and strobe
// RULE22 - Phase B internal; phases six states each
// RULE23 - Code 2 high: work register transfers
// RULE24 - Code 2 low: program counter from data
module aux_io_exec #(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Instruction issue
    input wire logic START,
    input wire logic [11:0] INSTR,
    // Shared bus, in and out per line plus one common enable
    input wire logic [11:0] BUS_IN,
    output logic [11:0] BUS_OUT,
    output logic BUS_OE,
    // Peripheral strobes and selects
    output logic BUS_ADDRESS_STROBE,
    output logic PERIPHERAL_SELECT_N,
    output logic TRANSFER_STROBE,
    // Peripheral control lines, active low
    input wire logic XFER_CODE_0_N,
    input wire logic XFER_CODE_1_N,
    input wire logic XFER_CODE_2_N,
    input wire logic SKIP_LINE_N,
    // Register view
    output logic [11:0] WORK_REGISTER,
    output logic [11:0] AUX_REGISTER,
    output logic [11:0] PROGRAM_COUNTER,
    output logic BUSY,
    output logic DONE
);

    // ------------------------------------------------------------
    // State and counter
    // ------------------------------------------------------------
    aux_io_pkg::seq_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt;
    logic cnt_last;
    logic [CNT_W-1:0] last_val;
    logic restart;

    logic [11:0] instr_q, work_q, work_d, aux_q, aux_d, pc_q, pc_d;
    logic [11:0] data_q, bus_out_q;
    logic c0_q, c1_q, c2_q, skp_q;
    logic bus_oe_q, strobe_q, sel_n_q, xtc_q, done_q, busy_q;

    // Restart the counter while idle so each fetch begins at state one
    assign restart = (state_q == aux_io_pkg::ST_IDLE);

    // RULE12 five state fetch
    // RULE22 six states per phase
    assign last_val = (state_q == aux_io_pkg::ST_FETCH) ?
        CNT_W'(aux_io_pkg::FETCH_STATES - 1) : CNT_W'(aux_io_pkg::PHASE_STATES - 1);

    state_counter #(
        .WIDTH(CNT_W)
    ) u_states (
        .REF_CLK(REF_CLK),
        .RST(RST),
        .restart(restart),
        .last_value(last_val),
        .count(cnt),
        .at_last(cnt_last)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Bit 0 is the most significant; index 11-n maps bit n
    // RULE9 io transfer decode
    wire is_iot = (instr_q[11:9] == aux_io_pkg::IOT_OPCODE);
    // Other opcode 7 words are not decoded here and only step the counter
    // RULE1 group 3 decode
    wire is_grp3 = (instr_q[11:9] == 3'h7) && instr_q[11-3] && instr_q[11-11];
    wire op_cla = instr_q[11-4];
    wire op_mqa = instr_q[11-5];
    wire op_mql = instr_q[11-7];

    // RULE2 clear first, then moves from cleared value
    wire [11:0] work_cleared = op_cla ? 12'h000 : work_q;
    // RULE3 OR aux into work
    // RULE5 clear then OR gives aux
    // RULE7 swap: with both set, work takes aux directly and aux takes work
    // RULE8 cleared work swapped leaves aux zero
    wire [11:0] g3_work = op_mqa ? (op_mql ? aux_q : (work_cleared | aux_q)) :
        (op_mql ? 12'h000 : work_cleared);
    // RULE4 work moves to aux
    // RULE6 cleared work into aux zeroes both
    wire [11:0] g3_aux = op_mql ? work_cleared : aux_q;

    // Sampled controls, active high meanings
    wire code2_hi = c2_q;
    wire code1_hi = c1_q;
    wire code0_hi = c0_q;
    wire skip_req = ~skp_q;

    // RULE23 work register transfer path
    wire [11:0] work_clr = code0_hi ? work_q : 12'h000;
    wire [11:0] io_work = code1_hi ? work_clr : (code0_hi ? (work_q | data_q) : data_q);
    // RULE24 relative or absolute jump, code 0 ignored
    wire [11:0] jump_pc = code1_hi ? (pc_q + data_q) : data_q;
    wire [11:0] base_pc = code2_hi ? pc_q : jump_pc;
    // Skip counts from the already stepped counter or the jump target, so it passes one word
    // RULE17 skip increment
    // RULE18 skip independent of code lines
    // RULE19 skip applied after jump
    wire [11:0] io_pc = skip_req ? (base_pc + 12'h001) : base_pc;

    // Phase timing helpers
    wire in_a = (state_q == aux_io_pkg::ST_PHASE_A);
    wire sample_now = in_a && (cnt == CNT_W'(aux_io_pkg::SAMPLE_STATE - 1));

    // ------------------------------------------------------------
    // Next state and register updates
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        work_d = work_q;
        aux_d = aux_q;
        pc_d = pc_q;
        case (state_q)
            aux_io_pkg::ST_IDLE: begin
                if (START) begin
                    state_d = aux_io_pkg::ST_FETCH;
                end
            end
            aux_io_pkg::ST_FETCH: begin
                if (cnt_last) begin
                    state_d = is_iot ? aux_io_pkg::ST_PHASE_A : aux_io_pkg::ST_OPR;
                    // Step past the fetched word before any jump or skip
                    pc_d = pc_q + 12'h001;
                end
            end
            aux_io_pkg::ST_OPR: begin
                if (is_grp3) begin
                    work_d = g3_work;
                    aux_d = g3_aux;
                end
                state_d = aux_io_pkg::ST_IDLE;
            end
            aux_io_pkg::ST_PHASE_A: begin
                if (cnt_last) begin
                    state_d = aux_io_pkg::ST_PHASE_B;
                end
            end
            aux_io_pkg::ST_PHASE_B: begin
                // RULE22 phase B does the work internally
                if (cnt_last) begin
                    if (code2_hi) begin
                        work_d = io_work;
                    end
                    pc_d = io_pc;
                    state_d = aux_io_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = aux_io_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_q <= aux_io_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Programmer visible registers; all three update on the same edge
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            work_q <= aux_io_pkg::WORK_RESET;
            aux_q <= aux_io_pkg::AUX_RESET;
            pc_q <= aux_io_pkg::PC_RESET;
        end else begin
            work_q <= work_d;
            aux_q <= aux_d;
            pc_q <= pc_d;
        end
    end

    // Instruction latch, taken only when idle so it stays stable
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            instr_q <= 12'h000;
        end else if (state_q == aux_io_pkg::ST_IDLE && START) begin
            instr_q <= INSTR;
        end
    end

    // ------------------------------------------------------------
    // Peripheral sampling
    // ------------------------------------------------------------
    // Lines are kept as pin levels; the decode above names their meaning
    // RULE20 sample data and lines at state 3 of phase A
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            data_q <= 12'h000;
            c0_q <= 1'b1;
            c1_q <= 1'b1;
            c2_q <= 1'b1;
            skp_q <= 1'b1;
        end else if (sample_now) begin
            data_q <= BUS_IN;
            c0_q <= XFER_CODE_0_N;
            c1_q <= XFER_CODE_1_N;
            c2_q <= XFER_CODE_2_N;
            skp_q <= SKIP_LINE_N;
        end
    end

    // ------------------------------------------------------------
    // Bus drive, registered outputs
    // ------------------------------------------------------------
    // Address strobe in first state of phase A; bus floats during sampling
    wire a_first = (state_q == aux_io_pkg::ST_FETCH) && cnt_last && is_iot;
    // Select wire covers states 2 to 5; the output flop delays it one state,
    // so the pin is low in states 3 to 6 and still low at the sampling edge
    wire sel_on = in_a && (cnt >= CNT_W'(1)) && (cnt < CNT_W'(aux_io_pkg::PHASE_STATES - 1));
    // Data out only after the sample so the bus is free for input first
    wire xtc_on = in_a && (cnt >= CNT_W'(aux_io_pkg::SAMPLE_STATE)) &&
        (cnt < CNT_W'(aux_io_pkg::PHASE_STATES - 1));
    // End of instruction seen one state ahead so the pulse lines up with idle
    wire finishing = (state_d == aux_io_pkg::ST_IDLE) && (state_q != aux_io_pkg::ST_IDLE);

    // RULE13 instruction on bus with strobe
    // RULE21 work data out during select and strobe
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            bus_out_q <= 12'h000;
            bus_oe_q <= 1'b0;
        end else begin
            bus_out_q <= a_first ? instr_q : work_q;
            bus_oe_q <= a_first || (sel_on && xtc_on);
        end
    end

    // RULE15 select driven low
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            strobe_q <= 1'b0;
            sel_n_q <= 1'b1;
            xtc_q <= 1'b0;
        end else begin
            strobe_q <= a_first;
            sel_n_q <= ~sel_on;
            xtc_q <= xtc_on;
        end
    end

    // Status flops; busy follows the next state so the port needs no decode
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= finishing;
            busy_q <= (state_d != aux_io_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------
    assign BUS_OUT = bus_out_q;
    assign BUS_OE = bus_oe_q;
    assign BUS_ADDRESS_STROBE = strobe_q;
    assign PERIPHERAL_SELECT_N = sel_n_q;
    assign TRANSFER_STROBE = xtc_q;
    assign WORK_REGISTER = work_q;
    assign AUX_REGISTER = aux_q;
    assign PROGRAM_COUNTER = pc_q;
    assign BUSY = busy_q;
    assign DONE = done_q;

endmodule
`default_nettype wire

// >>> logic/state_counter.sv
`timescale 1ns/100ps
`default_nettype none

// Counts internal states of one cycle and flags the last one
module state_counter #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Control
    input wire logic restart,
    input wire logic [WIDTH-1:0] last_value,
    // Status
    output logic [WIDTH-1:0] count,
    output logic at_last
);

    logic [WIDTH-1:0] count_q;

    assign count = count_q;
    assign at_last = (count_q == last_value);

    // Restart wins so a new cycle always begins at state one
    always_ff @(posedge REF_CLK) begin
        if (RST || restart || at_last) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> pkg/aux_io_pkg.sv
package aux_io_pkg;

    // ------------------------------------------------------------
    // Instruction fields and register reset values
    // ------------------------------------------------------------
    localparam int WORD_W = 12;
    localparam logic [2:0] IOT_OPCODE = 3'h6;
    localparam logic [11:0] WORK_RESET = 12'h000;
    localparam logic [11:0] AUX_RESET = 12'h000;
    localparam logic [11:0] PC_RESET = 12'h000;

    // ------------------------------------------------------------
    // Phase lengths in internal states
    // ------------------------------------------------------------
    localparam int FETCH_STATES = 5;
    localparam int PHASE_STATES = 6;
    localparam int SAMPLE_STATE = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_OPR = 3'b010,
        ST_PHASE_A = 3'b011,
        ST_PHASE_B = 3'b100
    } seq_state_t;

endpackage

// >>> test/aux_io_exec_props.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the aux and io transfer block
// ------------------------------------------------------------
module aux_io_exec_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Issue
    input wire logic START,
    input wire logic [11:0] INSTR,
    input wire logic BUSY,
    input wire logic DONE,
    // Bus side
    input wire logic [11:0] BUS_OUT,
    input wire logic BUS_OE,
    input wire logic BUS_ADDRESS_STROBE,
    input wire logic PERIPHERAL_SELECT_N,
    input wire logic TRANSFER_STROBE,
    // Registers
    input wire logic [11:0] WORK_REGISTER,
    input wire logic [11:0] AUX_REGISTER
);
    logic [11:0] instr_q;
    wire take = START && !BUSY;
    wire is_iot = INSTR[11:9] == 3'h6;
    wire no_g3 = INSTR[11:9] == 3'h7 && !(INSTR[8] && INSTR[0]);

    // Keep the accepted word to compare with the bus later
    always_ff @(posedge REF_CLK) begin
        if (take) begin
            instr_q <= INSTR;
        end
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    AST_STB_WORD:
        assert property (BUS_ADDRESS_STROBE |-> BUS_OE && BUS_OUT == instr_q)
        else $error("bus word wrong at strobe");
    AST_SEL_AFTER_STB:
        assert property (BUS_ADDRESS_STROBE |=> (PERIPHERAL_SELECT_N && !BUS_ADDRESS_STROBE)
            ##1 !PERIPHERAL_SELECT_N)
        else $error("select did not follow strobe");
    AST_SEL_LEN:
        assert property ($fell(PERIPHERAL_SELECT_N) |-> (!PERIPHERAL_SELECT_N)[*4] ##1 PERIPHERAL_SELECT_N)
        else $error("select length wrong");
    AST_XTC_DATA:
        assert property ($rose(TRANSFER_STROBE) |-> (TRANSFER_STROBE && !PERIPHERAL_SELECT_N
            && BUS_OE && BUS_OUT == WORK_REGISTER)[*2] ##1 !TRANSFER_STROBE)
        else $error("work data not on bus");
    AST_IOT_START:
        assert property (take && is_iot |-> ##[5:7] BUS_ADDRESS_STROBE)
        else $error("phase A late");
    AST_NO_BUS:
        assert property (take && !is_iot |-> (!BUS_ADDRESS_STROBE)[*8])
        else $error("strobe on non transfer");
    AST_IOT_LEN:
        assert property (BUS_ADDRESS_STROBE |-> ##[11:13] DONE)
        else $error("transfer length wrong");
    AST_NO_G3:
        assert property (take && no_g3 |=> ($stable(WORK_REGISTER) && $stable(AUX_REGISTER))[*7])
        else $error("registers moved");
    AST_DONE_PULSE:
        assert property (DONE |=> !DONE)
        else $error("done too long");
    AST_IDLE_QUIET:
        assert property (!BUSY |-> PERIPHERAL_SELECT_N && !TRANSFER_STROBE && !BUS_ADDRESS_STROBE)
        else $error("select active while idle");

    // Main scenarios reached
    cover property (take && is_iot);
    cover property ($rose(TRANSFER_STROBE));
    cover property (take && no_g3);
endmodule

bind aux_io_exec aux_io_exec_chk i_chk (.REF_CLK(REF_CLK), .RST(RST), .START(START),
    .INSTR(INSTR), .BUSY(BUSY), .DONE(DONE), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE),
    .BUS_ADDRESS_STROBE(BUS_ADDRESS_STROBE), .PERIPHERAL_SELECT_N(PERIPHERAL_SELECT_N),
    .TRANSFER_STROBE(TRANSFER_STROBE), .WORK_REGISTER(WORK_REGISTER),
    .AUX_REGISTER(AUX_REGISTER));

`default_nettype wire

// >>> test/aux_io_periph.sv
`timescale 1ns/100ps
`default_nettype none

// Peripheral interface model on the shared bus
module aux_io_periph (
    // Clock and strobes
    input wire logic ref_clk,
    input wire logic stb,
    input wire logic sel_n,
    input wire logic [11:0] bus_out,
    // Answer set by the bench, lines as {skip, c2, c1, c0}
    input wire logic [11:0] rsp_data,
    input wire logic [3:0] rsp_lines,
    // Toward the block, plus the latched address for the bench
    output logic [11:0] bus_in,
    output logic [3:0] lines,
    output logic [11:0] addr_q
);
    logic [11:0] last_q = 12'h000;

    always @(posedge ref_clk) begin
        if (stb) begin
            addr_q <= bus_out;
        end
        last_q <= bus_in;
    end

    // drive while selected; otherwise toggle the bus and invert the lines so stale data never matches
    assign bus_in = sel_n ? ~last_q : rsp_data;
    assign lines = sel_n ? ~rsp_lines : rsp_lines;
endmodule

`default_nettype wire

// >>> test/tb_aux_io_exec.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module tb_aux_io_exec;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [11:0] instr = 12'h000;
    logic [11:0] rsp_data = 12'h000;
    logic [3:0] rsp_lines = 4'hF;
    wire [11:0] bus_in, bus_out, work, aux, pc, addr;
    wire [3:0] lines;
    wire oe, stb, sel_n, transfer_strobe, busy, done;
    int num_errors = 0;
    int samples_checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    aux_io_exec i_dut (.REF_CLK(ref_clk), .RST(rst), .START(start), .INSTR(instr),
        .BUS_IN(bus_in), .BUS_OUT(bus_out), .BUS_OE(oe), .BUS_ADDRESS_STROBE(stb),
        .PERIPHERAL_SELECT_N(sel_n), .TRANSFER_STROBE(transfer_strobe), .XFER_CODE_0_N(lines[0]),
        .XFER_CODE_1_N(lines[1]), .XFER_CODE_2_N(lines[2]), .SKIP_LINE_N(lines[3]),
        .WORK_REGISTER(work), .AUX_REGISTER(aux), .PROGRAM_COUNTER(pc), .BUSY(busy),
        .DONE(done));

    aux_io_periph i_periph (.ref_clk(ref_clk), .stb(stb), .sel_n(sel_n), .bus_out(bus_out),
        .rsp_data(rsp_data), .rsp_lines(rsp_lines), .bus_in(bus_in), .lines(lines),
        .addr_q(addr));

    task automatic end_of_test();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One instruction; START held three cycles so the busy refusal is exercised
    task automatic op(input logic [11:0] ins, input logic [3:0] lv, input logic [11:0] d,
                      input logic [11:0] ew, input logic [11:0] ea, input logic [11:0] ep);
        int n;
        @(posedge ref_clk);
        start <= 1'b1;
        instr <= ins;
        rsp_lines <= lv;
        rsp_data <= d;
        repeat (3) @(posedge ref_clk);
        start <= 1'b0;
        n = 0;
        @(negedge ref_clk);
        while (done !== 1'b1) begin
            if (n == 40) begin
                num_errors++;
                end_of_test();
            end
            n++;
            @(negedge ref_clk);
        end
        `CHK(work, ew)
        `CHK(aux, ea)
        `CHK(pc, ep)
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        op(12'hC31, 4'hC, 12'h5A3, 12'h5A3, 12'h000, 12'h001);
        `CHK(addr, 12'hC31)
        `CHK(addr[8:3], 6'h06)
        op(12'hF11, 4'hF, 12'h000, 12'h000, 12'h5A3, 12'h002);
        op(12'hC32, 4'hD, 12'h0F0, 12'h0F0, 12'h5A3, 12'h003);
        op(12'hF41, 4'hF, 12'h000, 12'h5F3, 12'h5A3, 12'h004);
        op(12'hF51, 4'hF, 12'h000, 12'h5A3, 12'h5F3, 12'h005);
        op(12'hFC1, 4'hF, 12'h000, 12'h5F3, 12'h5F3, 12'h006);
        op(12'hC33, 4'h6, 12'hABC, 12'h000, 12'h5F3, 12'h008);
        op(12'hFD1, 4'hF, 12'h000, 12'h5F3, 12'h000, 12'h009);
        op(12'hF11, 4'hF, 12'h000, 12'h000, 12'h5F3, 12'h00A);
        op(12'hC34, 4'hC, 12'h123, 12'h123, 12'h5F3, 12'h00B);
        op(12'hF40, 4'hF, 12'h000, 12'h123, 12'h5F3, 12'h00C);
        op(12'hE41, 4'hF, 12'h000, 12'h123, 12'h5F3, 12'h00D);
        op(12'hF91, 4'hF, 12'h000, 12'h000, 12'h000, 12'h00E);
        op(12'hC35, 4'h2, 12'h010, 12'h000, 12'h000, 12'h020);
        op(12'hC36, 4'h9, 12'h200, 12'h000, 12'h000, 12'h200);
        op(12'hC37, 4'hB, 12'h0FF, 12'h000, 12'h000, 12'h300);
        end_of_test();
    end
endmodule

`default_nettype wire
